/* File: src/core_decode_pkg.sv */
// Shared constants for the instruction decode and execute core
package core_decode_pkg;

   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_FETCH = 2'b01,
      ST_EXEC  = 2'b10
   } core_state_t;

   // ----------------------------------------------------------------
   // Opcodes and opcode fields
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_PRODUCT     = 8'h42;
   localparam logic [7:0] OP_BRANCH_CALL = 8'had;
   localparam logic [3:0] BRANCH_ROW     = 4'h2;

   localparam logic [3:0] MODE_IMM = 4'ha;
   localparam logic [3:0] MODE_DIR = 4'hb;
   localparam logic [3:0] MODE_EXT = 4'hc;
   localparam logic [3:0] MODE_IX2 = 4'hd;
   localparam logic [3:0] MODE_IX1 = 4'he;
   localparam logic [3:0] MODE_IX  = 4'hf;

   localparam logic [3:0] FN_SUB = 4'h0;
   localparam logic [3:0] FN_CMP = 4'h1;
   localparam logic [3:0] FN_SBC = 4'h2;
   localparam logic [3:0] FN_CPX = 4'h3;
   localparam logic [3:0] FN_AND = 4'h4;
   localparam logic [3:0] FN_BIT = 4'h5;
   localparam logic [3:0] FN_LDA = 4'h6;
   localparam logic [3:0] FN_STA = 4'h7;
   localparam logic [3:0] FN_EOR = 4'h8;
   localparam logic [3:0] FN_ADC = 4'h9;
   localparam logic [3:0] FN_ORA = 4'ha;
   localparam logic [3:0] FN_ADD = 4'hb;
   localparam logic [3:0] FN_JMP = 4'hc;
   localparam logic [3:0] FN_JSR = 4'hd;
   localparam logic [3:0] FN_LDX = 4'he;
   localparam logic [3:0] FN_STX = 4'hf;

   // ----------------------------------------------------------------
   // Instruction lengths and cycle counts
   // ----------------------------------------------------------------
   localparam logic [1:0] BYTES_IMM = 2'h2;
   localparam logic [1:0] BYTES_DIR = 2'h2;
   localparam logic [1:0] BYTES_EXT = 2'h3;
   localparam logic [1:0] BYTES_IX  = 2'h1;
   localparam logic [1:0] BYTES_IX1 = 2'h2;
   localparam logic [1:0] BYTES_IX2 = 2'h3;
   localparam logic [1:0] BYTES_REL = 2'h2;
   localparam logic [1:0] BYTES_ONE = 2'h1;

   localparam logic [3:0] CYC_IMM     = 4'h2;
   localparam logic [3:0] CYC_DIR     = 4'h3;
   localparam logic [3:0] CYC_EXT     = 4'h4;
   localparam logic [3:0] CYC_IX      = 4'h3;
   localparam logic [3:0] CYC_IX1     = 4'h4;
   localparam logic [3:0] CYC_IX2     = 4'h5;
   localparam logic [3:0] CYC_BRANCH  = 4'h3;
   localparam logic [3:0] CYC_CALL    = 4'h6;
   localparam logic [3:0] CYC_PRODUCT = 4'hb;
   localparam logic [3:0] CYC_ILLEGAL = 4'h2;
   localparam logic [3:0] CYC_STORE_X = 4'h1;
   localparam logic [3:0] CYC_JSR_X   = 4'h2;

   // ----------------------------------------------------------------
   // Values after reset, and the fixed stack page
   // ----------------------------------------------------------------
   localparam logic [15:0] PC_RESET   = 16'h0000;
   localparam logic [5:0]  SP_RESET   = 6'h3f;
   localparam logic [9:0]  STACK_PAGE = 10'h003;
   localparam logic        MASK_RESET = 1'b1;

endpackage : core_decode_pkg

/* File: src/core_alu.sv */
// Arithmetic and logic unit for the register/memory operations
module core_alu (
   input  wire logic [3:0] fn,       // Operation code, low opcode nibble
   input  wire logic [7:0] acc,      // Accumulator
   input  wire logic [7:0] idx,      // Index register
   input  wire logic [7:0] opd,      // Memory operand
   input  wire logic       c_in,     // Carry flag
   output logic      [7:0] res,      // Result
   output logic            c_out,    // New carry or borrow
   output logic            h_out,    // New half carry
   output logic            wr_acc,   // Result goes to accumulator
   output logic            wr_idx,   // Result goes to index register
   output logic            upd_nz,   // Update negative and zero
   output logic            upd_c,    // Update carry
   output logic            upd_h     // Update half carry
);
   logic [8:0] wide;
   logic [4:0] nib;

   always_comb begin
      wide   = 9'h000;
      nib    = 5'h00;
      res    = acc;
      c_out  = c_in;
      h_out  = 1'b0;
      wr_acc = 1'b0;
      wr_idx = 1'b0;
      upd_nz = 1'b1;
      upd_c  = 1'b0;
      upd_h  = 1'b0;
      case (fn)
         core_decode_pkg::FN_SUB, core_decode_pkg::FN_CMP, core_decode_pkg::FN_SBC: begin
            // Borrow enters only for subtract with borrow
            wide   = {1'b0, acc} - {1'b0, opd} - {8'h00, c_in & (fn == core_decode_pkg::FN_SBC)};
            res    = wide[7:0];
            c_out  = wide[8];
            upd_c  = 1'b1;
            wr_acc = (fn != core_decode_pkg::FN_CMP);
         end
         core_decode_pkg::FN_CPX: begin
            wide  = {1'b0, idx} - {1'b0, opd};
            res   = wide[7:0];
            c_out = wide[8];
            upd_c = 1'b1;
         end
         core_decode_pkg::FN_ADD, core_decode_pkg::FN_ADC: begin
            nib    = {1'b0, acc[3:0]} + {1'b0, opd[3:0]} + {4'h0, c_in & (fn == core_decode_pkg::FN_ADC)};
            wide   = {1'b0, acc} + {1'b0, opd} + {8'h00, c_in & (fn == core_decode_pkg::FN_ADC)};
            res    = wide[7:0];
            c_out  = wide[8];
            h_out  = nib[4];
            upd_c  = 1'b1;
            upd_h  = 1'b1;
            wr_acc = 1'b1;
         end
         core_decode_pkg::FN_AND: begin
            res    = acc & opd;
            wr_acc = 1'b1;
         end
         core_decode_pkg::FN_BIT: begin
            res = acc & opd;
         end
         core_decode_pkg::FN_EOR: begin
            res    = acc ^ opd;
            wr_acc = 1'b1;
         end
         core_decode_pkg::FN_ORA: begin
            res    = acc | opd;
            wr_acc = 1'b1;
         end
         core_decode_pkg::FN_LDA: begin
            res    = opd;
            wr_acc = 1'b1;
         end
         core_decode_pkg::FN_LDX: begin
            res    = opd;
            wr_idx = 1'b1;
         end
         core_decode_pkg::FN_STA: res = acc;
         core_decode_pkg::FN_STX: res = idx;
         default: upd_nz = 1'b0;
      endcase
   end
endmodule : core_alu

/* File: src/core_exec.sv */
// Instruction sequencer: register/memory, multiply and relative branch groups
// How it works
// - Product of index and accumulator splits high/low
// - Product: one byte, eleven cycles
// - Add with carry, six addressing opcodes
// - Subtract with borrow, six addressing opcodes
// - Exclusive or into accumulator, six opcodes
// - Byte and cycle counts per addressing mode
// - Bit test sets flags, keeps accumulator
// - Lower-or-same branches on carry or zero
// - Carry-clear and higher-same share one opcode
// - Half-carry clear and set branches
// - Interrupt mask clear and set branches
// - Interrupt line low and high branches
// - Branches three cycles, relative call six
// - Additions set half carry from bit three
// - Untaken branch only advances the counter
module core_exec (
   input  wire logic        core_clk,    // Processor clock
   input  wire logic        rst,         // Asynchronous reset, active high
   input  wire logic [7:0]  mem_rdata,   // Read data for mem_addr, same cycle
   input  wire logic        irq_line,    // External interrupt request pin level
   output logic      [15:0] mem_addr,    // Memory address
   output logic      [7:0]  mem_wdata,   // Memory write data
   output logic             mem_we,      // Memory write strobe
   output logic      [7:0]  acc,         // Accumulator
   output logic      [7:0]  idx,         // Index register
   output logic      [15:0] pc,          // Program counter
   output logic      [4:0]  ccr,         // Flags {h, i, n, z, c}
   output logic             instr_done,  // Last cycle of an instruction
   output logic             illegal_op   // Last cycle of an opcode left unexecuted
);
   core_decode_pkg::core_state_t st_q, st_d;
   logic [3:0]  cyc_q, cyc_d;
   logic [7:0]  op_q, op_d, lo_q, lo_d, hi_q, hi_d, data_q, data_d;
   logic [7:0]  a_q, a_d, x_q, x_d;
   logic [15:0] pc_q, pc_d;
   logic [5:0]  sp_q, sp_d;
   logic        h_q, h_d, i_q, i_d, n_q, n_d, z_q, z_d, c_q, c_d;
   logic        irq_s1_q, irq_s2_q;

   logic [7:0]  cur_op, m_val, alu_res;
   logic [3:0]  mode, fn, ncyc;
   logic [1:0]  nbytes;
   logic        is_rm, is_br, is_mul, is_call_rel, is_store, is_jmp, is_jsr, is_call, legal;
   logic        done, push_lo, push_hi, taken, odd_cond;
   logic [15:0] ea, rel_target, product, jmp_ea;
   logic        alu_c, alu_h, wr_acc, wr_idx, upd_nz, upd_c, upd_h;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   // Decoding from the bus in the fetch cycle avoids a wasted cycle per opcode
   assign cur_op = (st_q == core_decode_pkg::ST_FETCH) ? mem_rdata : op_q;
   assign mode   = cur_op[7:4];
   assign fn     = cur_op[3:0];

   always_comb begin
      is_call_rel = (cur_op == core_decode_pkg::OP_BRANCH_CALL);
      is_br       = (mode == core_decode_pkg::BRANCH_ROW);
      is_mul      = (cur_op == core_decode_pkg::OP_PRODUCT);
      is_rm       = (mode >= core_decode_pkg::MODE_IMM) && !is_call_rel &&
                    !((mode == core_decode_pkg::MODE_IMM) && ((fn == core_decode_pkg::FN_STA) ||
                      (fn == core_decode_pkg::FN_STX) || (fn == core_decode_pkg::FN_JMP)));
      is_store    = is_rm && ((fn == core_decode_pkg::FN_STA) || (fn == core_decode_pkg::FN_STX));
      is_jmp      = is_rm && (fn == core_decode_pkg::FN_JMP);
      is_jsr      = is_rm && (fn == core_decode_pkg::FN_JSR);
      is_call     = is_jsr || is_call_rel;
      legal       = is_rm || is_br || is_mul || is_call_rel;
      nbytes      = core_decode_pkg::BYTES_ONE;
      ncyc        = core_decode_pkg::CYC_ILLEGAL;
      if (is_call_rel) begin
         nbytes = core_decode_pkg::BYTES_REL;
         ncyc   = core_decode_pkg::CYC_CALL;
      end else if (is_br) begin
         nbytes = core_decode_pkg::BYTES_REL;
         ncyc   = core_decode_pkg::CYC_BRANCH;
      end else if (is_mul) begin
         nbytes = core_decode_pkg::BYTES_ONE;
         ncyc   = core_decode_pkg::CYC_PRODUCT;
      end else if (is_rm) begin
         case (mode)
            core_decode_pkg::MODE_IMM: begin
               nbytes = core_decode_pkg::BYTES_IMM;
               ncyc   = core_decode_pkg::CYC_IMM;
            end
            core_decode_pkg::MODE_DIR: begin
               nbytes = core_decode_pkg::BYTES_DIR;
               ncyc   = core_decode_pkg::CYC_DIR;
            end
            core_decode_pkg::MODE_EXT: begin
               nbytes = core_decode_pkg::BYTES_EXT;
               ncyc   = core_decode_pkg::CYC_EXT;
            end
            core_decode_pkg::MODE_IX2: begin
               nbytes = core_decode_pkg::BYTES_IX2;
               ncyc   = core_decode_pkg::CYC_IX2;
            end
            core_decode_pkg::MODE_IX1: begin
               nbytes = core_decode_pkg::BYTES_IX1;
               ncyc   = core_decode_pkg::CYC_IX1;
            end
            default: begin
               nbytes = core_decode_pkg::BYTES_IX;
               ncyc   = core_decode_pkg::CYC_IX;
            end
         endcase
         if (is_store) begin
            ncyc = ncyc + core_decode_pkg::CYC_STORE_X;
         end else if (is_jmp) begin
            ncyc = ncyc - core_decode_pkg::CYC_STORE_X;
         end else if (is_jsr) begin
            ncyc = ncyc + core_decode_pkg::CYC_JSR_X;
         end
      end
   end

   // ----------------------------------------------------------------
   // Addressing and branch conditions
   // ----------------------------------------------------------------
   always_comb begin
      case (mode)
         core_decode_pkg::MODE_DIR: ea = {8'h00, lo_q};
         core_decode_pkg::MODE_EXT: ea = {hi_q, lo_q};
         core_decode_pkg::MODE_IX2: ea = {hi_q, lo_q} + {8'h00, x_q};
         core_decode_pkg::MODE_IX1: ea = {8'h00, lo_q} + {8'h00, x_q};
         default:                   ea = {8'h00, x_q};
      endcase
   end

   // Pairs share a condition; the even opcode of each pair is the inverse
   always_comb begin
      case (fn[3:1])
         3'h0:    odd_cond = 1'b0;
         3'h1:    odd_cond = c_q | z_q;
         3'h2:    odd_cond = c_q;
         3'h3:    odd_cond = z_q;
         3'h4:    odd_cond = h_q;
         3'h5:    odd_cond = n_q;
         3'h6:    odd_cond = i_q;
         3'h7:    odd_cond = irq_s2_q;
         default: odd_cond = 1'b0;
      endcase
      taken = fn[0] ? odd_cond : !odd_cond;
   end

   // Counter already points past both bytes when the offset is added
   assign rel_target = pc_q + {{8{lo_q[7]}}, lo_q};
   assign product    = 16'(x_q) * 16'(a_q);
   // Direct and extended jumps end while their last address byte is still on the bus
   assign jmp_ea     = (cyc_q < {2'b00, nbytes}) ?
                       ((mode == core_decode_pkg::MODE_EXT) ? {hi_q, mem_rdata} : {8'h00, mem_rdata}) : ea;

   // ----------------------------------------------------------------
   // Bus control
   // ----------------------------------------------------------------
   assign done    = (st_q == core_decode_pkg::ST_EXEC) && (cyc_q == ncyc - 4'h1);
   assign push_hi = (st_q == core_decode_pkg::ST_EXEC) && is_call && done;
   assign push_lo = (st_q == core_decode_pkg::ST_EXEC) && is_call && (cyc_q == ncyc - 4'h2);
   // Immediate operands and single-cycle reads arrive on the bus in the commit cycle
   assign m_val   = ((mode == core_decode_pkg::MODE_IMM) || (cyc_q == {2'b00, nbytes})) ? mem_rdata : data_q;

   always_comb begin
      mem_wdata = 8'h00;
      if (st_q == core_decode_pkg::ST_FETCH || cyc_q < {2'b00, nbytes}) begin
         mem_addr = pc_q;
      end else if (push_lo || push_hi) begin
         mem_addr  = {core_decode_pkg::STACK_PAGE, sp_q};
         mem_wdata = push_lo ? pc_q[7:0] : pc_q[15:8];
      end else begin
         mem_addr  = ea;
         mem_wdata = (fn == core_decode_pkg::FN_STX) ? x_q : a_q;
      end
      mem_we = push_lo || push_hi || (is_store && done);
   end

   core_alu u_alu (
      .fn     (fn),
      .acc    (a_q),
      .idx    (x_q),
      .opd    (m_val),
      .c_in   (c_q),
      .res    (alu_res),
      .c_out  (alu_c),
      .h_out  (alu_h),
      .wr_acc (wr_acc),
      .wr_idx (wr_idx),
      .upd_nz (upd_nz),
      .upd_c  (upd_c),
      .upd_h  (upd_h)
   );

   // ----------------------------------------------------------------
   // Sequencer and registers
   // ----------------------------------------------------------------
   always_comb begin
      st_d = st_q;   cyc_d = cyc_q;   op_d = op_q;   lo_d = lo_q;   hi_d = hi_q;
      data_d = data_q;   a_d = a_q;   x_d = x_q;   pc_d = pc_q;   sp_d = sp_q;
      h_d = h_q;   i_d = i_q;   n_d = n_q;   z_d = z_q;   c_d = c_q;
      case (st_q)
         core_decode_pkg::ST_FETCH: begin
            op_d  = mem_rdata;
            pc_d  = pc_q + 16'h0001;
            cyc_d = 4'h1;
            st_d  = core_decode_pkg::ST_EXEC;
         end
         core_decode_pkg::ST_EXEC: begin
            cyc_d = cyc_q + 4'h1;
            if (cyc_q < {2'b00, nbytes}) begin
               pc_d = pc_q + 16'h0001;
               if (cyc_q == 4'h1 && nbytes == core_decode_pkg::BYTES_EXT) begin
                  hi_d = mem_rdata;
               end else begin
                  lo_d = mem_rdata;
               end
            end
            if (cyc_q == {2'b00, nbytes}) begin
               data_d = mem_rdata;
            end
            if (push_lo || push_hi) begin
               sp_d = sp_q - 6'h01;
            end
            if (done) begin
               st_d  = core_decode_pkg::ST_FETCH;
               cyc_d = 4'h0;
               if (is_mul) begin
                  x_d = product[15:8];
                  a_d = product[7:0];
                  h_d = 1'b0;
                  c_d = 1'b0;
               end else if (is_br || is_call_rel) begin
                  if (is_call_rel || taken) begin
                     pc_d = rel_target;
                  end
               end else if (is_rm) begin
                  if (is_jmp || is_jsr) begin
                     pc_d = jmp_ea;
                  end
                  if (wr_acc) begin
                     a_d = alu_res;
                  end
                  if (wr_idx) begin
                     x_d = alu_res;
                  end
                  if (upd_nz) begin
                     n_d = alu_res[7];
                     z_d = (alu_res == 8'h00);
                  end
                  if (upd_c) begin
                     c_d = alu_c;
                  end
                  if (upd_h) begin
                     h_d = alu_h;
                  end
               end
            end
         end
         default: begin
            st_d  = core_decode_pkg::ST_FETCH;
            cyc_d = 4'h0;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_q <= core_decode_pkg::ST_FETCH;   cyc_q <= 4'h0;
         op_q <= 8'h00;   lo_q <= 8'h00;   hi_q <= 8'h00;   data_q <= 8'h00;
         a_q <= 8'h00;   x_q <= 8'h00;
         pc_q <= core_decode_pkg::PC_RESET;   sp_q <= core_decode_pkg::SP_RESET;
         h_q <= 1'b0;   i_q <= core_decode_pkg::MASK_RESET;   n_q <= 1'b0;   z_q <= 1'b0;   c_q <= 1'b0;
      end else begin
         st_q <= st_d;   cyc_q <= cyc_d;
         op_q <= op_d;   lo_q <= lo_d;   hi_q <= hi_d;   data_q <= data_d;
         a_q <= a_d;   x_q <= x_d;   pc_q <= pc_d;   sp_q <= sp_d;
         h_q <= h_d;   i_q <= i_d;   n_q <= n_d;   z_q <= z_d;   c_q <= c_d;
      end
   end

   // Pin level is resynchronised; the branch sees it two edges late
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         irq_s1_q <= 1'b0;
         irq_s2_q <= 1'b0;
      end else begin
         irq_s1_q <= irq_line;
         irq_s2_q <= irq_s1_q;
      end
   end

   assign acc        = a_q;
   assign idx        = x_q;
   assign pc         = pc_q;
   assign ccr        = {h_q, i_q, n_q, z_q, c_q};
   assign instr_done = done;
   assign illegal_op = done && !legal;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic        fetch_now;
   logic [7:0]  adc_exp, sbc_exp, eor_exp;
   logic        hc_exp;
   assign fetch_now = (st_q == core_decode_pkg::ST_FETCH);
   assign adc_exp   = a_q + m_val + {7'h00, c_q};
   assign sbc_exp   = a_q - m_val - {7'h00, c_q};
   assign eor_exp   = a_q ^ m_val;
   assign hc_exp    = ({1'b0, a_q[3:0]} + {1'b0, m_val[3:0]}) > 5'h0f;

   sequence s_fetch_product;
      fetch_now && mem_rdata == 8'h42;
   endsequence
   sequence s_end_after_ten;
      !done [*8] ##1 !done ##1 done;
   endsequence

   a_product_result: assert property (@(posedge core_clk) disable iff (rst)
      done && is_mul |=> {x_q, a_q} == $past(product) && !h_q && !c_q)
      else $error("product not placed in index and accumulator");
   a_product_cycles: assert property (@(posedge core_clk) disable iff (rst)
      s_fetch_product |=> s_end_after_ten ##1 fetch_now && pc_q == $past(pc_q, 11) + 16'h0001)
      else $error("product length wrong");
   a_adc_sum: assert property (@(posedge core_clk) disable iff (rst)
      done && is_rm && fn == 4'h9 |=> a_q == $past(adc_exp))
      else $error("add with carry result wrong");
   a_sbc_diff: assert property (@(posedge core_clk) disable iff (rst)
      done && is_rm && fn == 4'h2 |=> a_q == $past(sbc_exp))
      else $error("subtract with borrow result wrong");
   a_eor_value: assert property (@(posedge core_clk) disable iff (rst)
      done && is_rm && fn == 4'h8 |=> a_q == $past(eor_exp))
      else $error("exclusive or result wrong");
   a_mode_cycles: assert property (@(posedge core_clk) disable iff (rst)
      fetch_now && mem_rdata == 8'hc1 |-> ##3 done ##1 pc_q == $past(pc_q, 4) + 16'h0003)
      else $error("extended compare timing wrong");
   a_bit_keeps_acc: assert property (@(posedge core_clk) disable iff (rst)
      done && is_rm && fn == 4'h5 |=> $stable(a_q) && z_q == ($past(eor_exp | ~a_q) == 8'hff))
      else $error("bit test changed accumulator or zero flag");
   a_bls_taken: assert property (@(posedge core_clk) disable iff (rst)
      done && op_q == 8'h23 && (c_q || z_q) |=> pc_q == $past(rel_target))
      else $error("lower or same branch not taken");
   a_branch_cycles: assert property (@(posedge core_clk) disable iff (rst)
      fetch_now && mem_rdata[7:4] == 4'h2 |-> !done ##1 !done ##1 done)
      else $error("relative branch not three cycles");
   a_call_cycles: assert property (@(posedge core_clk) disable iff (rst)
      fetch_now && mem_rdata == 8'had |-> ##3 !mem_we ##1 mem_we ##1 mem_we && done)
      else $error("relative call not six cycles");
   a_untaken_still: assert property (@(posedge core_clk) disable iff (rst)
      done && is_br && !taken |=> pc_q == $past(pc_q) && $stable(a_q) && $stable(ccr))
      else $error("untaken branch changed state");
   a_half_carry: assert property (@(posedge core_clk) disable iff (rst)
      done && is_rm && fn == 4'hb |=> h_q == $past(hc_exp))
      else $error("half carry wrong after add");
endmodule : core_exec

/* File: verification/mem_model.sv */
// Program and data memory with same-cycle read for the core
module mem_model (
   input  wire logic        core_clk,  // Processor clock
   input  wire logic [15:0] mem_addr,  // Address
   input  wire logic [7:0]  mem_wdata, // Write data
   input  wire logic        mem_we,    // Write strobe
   output logic      [7:0]  mem_rdata  // Read data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:65535];
   // No wait states: the core expects the byte in the same cycle
   assign mem_rdata = mem[mem_addr];
   always @(posedge core_clk) begin
      if (mem_we) mem[mem_addr] <= mem_wdata;
   end
endmodule : mem_model

/* File: verification/tb_cpu_core_instruction_decode.sv */
// Self-checking bench for the instruction decode and execute core
module tb_cpu_core_instruction_decode;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic        irq_line = 1'b0;
   logic [7:0]  mem_rdata, mem_wdata, acc, idx;
   logic [15:0] mem_addr, pc;
   logic        mem_we, instr_done, illegal_op;
   logic [4:0]  ccr;
   int          bad_count = 0;
   int          n_checks = 0;
   always #10 core_clk = ~core_clk;
   core_exec dut (.core_clk(core_clk), .rst(rst), .mem_rdata(mem_rdata), .irq_line(irq_line),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we), .acc(acc), .idx(idx),
      .pc(pc), .ccr(ccr), .instr_done(instr_done), .illegal_op(illegal_op));
   mem_model mem (.core_clk(core_clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_we(mem_we), .mem_rdata(mem_rdata));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // Memory is refilled under reset so a running core cannot disturb it
   task automatic boot(input logic [7:0] prog[$], input logic irq);
      @(posedge core_clk);
      rst <= 1'b1;
      irq_line <= irq;
      @(negedge core_clk);
      for (int i = 0; i < 65536; i++) begin
         mem.mem[i] = 8'h9d;
      end
      foreach (prog[i]) mem.mem[i] = prog[i];
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
   endtask : boot
   task automatic exec(input int cyc);
      int n;
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (instr_done !== 1'b1 && n < 20);
      chk("cycles", 16'(n), 16'(cyc));
      chk("illegal", {15'h0, illegal_op}, 16'h0);
      @(posedge core_clk);
      #1;
   endtask : exec
   task automatic test_done();
      $display("Checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_product();
      boot({8'ha6, 8'hc8, 8'hae, 8'h0d, 8'h42}, 1'b0);
      exec(2);
      exec(2);
      exec(11);
      chk("product", {idx, acc}, 16'h0a28);
      chk("pc", pc, 16'h0005);
   endtask : t_product
   task automatic t_arith();
      boot({8'ha6, 8'h0f, 8'ha9, 8'h01, 8'hb2, 8'h40, 8'hf8, 8'he5, 8'h41,
            8'hd9, 8'h00, 8'h42, 8'hc1, 8'h00, 8'h42}, 1'b0);
      mem.mem[16'h40] = 8'h11;
      mem.mem[16'h41] = 8'h06;
      mem.mem[16'h42] = 8'h01;
      exec(2);
      exec(2);
      chk("adc", {3'h0, ccr[4], 4'h0, acc}, 16'h1010);
      exec(3);
      chk("sbc", {7'h0, ccr[0], acc}, 16'h01ff);
      exec(3);
      chk("eor", {8'h0, acc}, 16'h0059);
      exec(4);
      chk("bit", {7'h0, ccr[1], acc}, 16'h0159);
      exec(5);
      chk("adc ix2", {8'h0, acc}, 16'h005b);
      exec(4);
      chk("cmp", {3'h0, ccr, acc}, 16'h085b);
      chk("pc", pc, 16'h000f);
   endtask : t_arith
   task automatic t_branch();
      logic [7:0] ops [10] = '{8'h23, 8'h24, 8'h28, 8'h29, 8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h2e, 8'h2f};
      logic take [10] = '{0, 1, 1, 0, 0, 1, 1, 0, 0, 1};
      for (int i = 0; i < 10; i++) begin
         boot({ops[i], (i % 2) ? 8'hfc : 8'h04}, i >= 8);
         exec(3);
         chk("branch", pc, take[i] ? ((i % 2) ? 16'hfffe : 16'h0006) : 16'h0002);
      end
      boot({8'ha1, 8'h00, 8'h23, 8'hfc}, 1'b0);
      exec(2);
      exec(3);
      chk("lower same", pc, 16'h0000);
      boot({8'had, 8'h10}, 1'b0);
      exec(6);
      chk("call", pc, 16'h0012);
      chk("ret", {mem.mem[16'hfe], mem.mem[16'hff]}, 16'h0002);
   endtask : t_branch
   task automatic t_move();
      boot({8'ha6, 8'h5a, 8'hab, 8'h08, 8'hb7, 8'h50, 8'hbc, 8'h20}, 1'b0);
      exec(2);
      exec(2);
      chk("add", {3'h0, ccr[4], 4'h0, acc}, 16'h1062);
      exec(4);
      chk("store", {8'h0, mem.mem[16'h50]}, 16'h0062);
      exec(2);
      chk("jump", pc, 16'h0020);
   endtask : t_move
   initial begin
      #100000;
      bad_count++;
      test_done();
   end
   initial begin
      t_product();
      t_arith();
      t_branch();
      t_move();
      test_done();
   end
endmodule : tb_cpu_core_instruction_decode
